/* common/audio_serial_pkg.sv */
package audio_serial_pkg;
  // register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] TX_CSR_OFS = 8'h00;
  localparam logic [7:0] TX_WM_OFS = 8'h04;
  localparam logic [7:0] TX_MASK_OFS = 8'h08;
  localparam logic [7:0] TX_DATA_OFS = 8'h0C;
  localparam logic [7:0] RX_CSR_OFS = 8'h10;
  localparam logic [7:0] RX_WM_OFS = 8'h14;
  localparam logic [7:0] RX_MASK_OFS = 8'h18;
  localparam logic [7:0] RX_DATA_OFS = 8'h1C;
  localparam logic [7:0] LINK_CFG_OFS = 8'h20;

  // control and status register fields, same layout for both directions
  localparam int CSR_EN_BIT = 0;
  localparam int CSR_REQ_DE_BIT = 1;
  localparam int CSR_WARN_DE_BIT = 2;
  localparam int CSR_REQ_IE_BIT = 3;
  localparam int CSR_WARN_IE_BIT = 4;
  localparam int CSR_CONT_BIT = 5;
  localparam int CSR_CTRL_W = 6;
  localparam int CSR_PTR_RST_BIT = 8;
  localparam int CSR_REQ_FLAG_BIT = 16;
  localparam int CSR_WARN_FLAG_BIT = 17;
  localparam int CSR_ERR_FLAG_BIT = 18;

  // link configuration fields
  localparam int LINE_EN_BIT = 0;
  localparam int BCLK_DIR_BIT = 1;
  localparam int FS_DIR_BIT = 2;
  localparam int FS_EARLY_BIT = 3;
  localparam int FSW_LSB = 8;
  localparam int FSW_W = 5;
  localparam int WW_LSB = 16;
  localparam int WW_W = 5;
  localparam int SLOTS_LSB = 24;
  localparam int SLOTS_W = 4;

  // sizes
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int LEVEL_W = 4;
  localparam int MASK_W = 16;

  // reset values
  localparam logic [CSR_CTRL_W-1:0] CSR_RST = 6'h00;
  localparam logic [LEVEL_W-1:0] WM_RST = 4'h0;
  localparam logic [LEVEL_W-1:0] WM_MAX = 4'h8;
  localparam logic [MASK_W-1:0] MASK_RST = 16'h0000;
  localparam logic [FSW_W-1:0] FSW_RST = 5'h1F;
  localparam logic [WW_W-1:0] WW_RST = 5'h1F;
  localparam logic [SLOTS_W-1:0] SLOTS_RST = 4'h1;

  // bit clock half period in mclk cycles when generated internally
  localparam int BCLK_HALF_CYCLES = 4;
endpackage

/* hdl/audio_serial_fifo_ctrl.sv */
// What this block does
// - separate transmit and receive FIFOs of eight 32-bit words behind data registers
// - each direction has a programmable watermark of at most eight entries
// - request flag: transmit level at or below watermark, receive level above it
// - warning flag while transmit FIFO empty or receive FIFO full, self clearing
// - each direction has its own interrupt and DMA request from the same flags
// - a FIFO error halts that direction unless continue-on-error is set
// - a halted direction resumes once software clears the error flag or sets continue-on-error
// - each direction has a 16-bit slot mask, one bit per slot
// - clear mask bit moves the slot through the FIFO, set bit skips it
// - frame sync and bit clock direction bits select internal or external signals
// - enabling a master direction starts bit clock and frame sync outputs
// - DMA and interrupt outputs are gated by their enable bits
// - writing the pointer reset bit resets FIFO read and write pointers
// - frame format fields hold value minus one
// - early frame sync asserts one bit clock before the first data bit
// - frame sync width field gives active length in bit clocks minus one
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module audio_serial_fifo_ctrl #(
  parameter int BCLK_HALF = audio_serial_pkg::BCLK_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [audio_serial_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bclk_in,
  input wire logic fs_in,
  input wire logic rxd_in,
  output logic bclk_out,
  output logic bclk_oe,
  output logic fs_out,
  output logic fs_oe,
  output logic txd_out,
  output logic tx_irq,
  output logic rx_irq,
  output logic tx_dma_req,
  output logic rx_dma_req
);
  localparam int DW = audio_serial_pkg::DATA_W;
  localparam int LW = audio_serial_pkg::LEVEL_W;
  localparam int DIV_W = (BCLK_HALF > 1) ? $clog2(BCLK_HALF) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_HALF - 1);

  // registers
  logic [audio_serial_pkg::CSR_CTRL_W-1:0] tx_ctrl_q;
  logic [audio_serial_pkg::CSR_CTRL_W-1:0] rx_ctrl_q;
  logic [LW-1:0] tx_wm_q;
  logic [LW-1:0] rx_wm_q;
  logic [audio_serial_pkg::MASK_W-1:0] tx_mask_q;
  logic [audio_serial_pkg::MASK_W-1:0] rx_mask_q;
  logic line_en_q;
  logic bclk_dir_q;
  logic fs_dir_q;
  logic fs_early_q;
  logic [audio_serial_pkg::FSW_W-1:0] fsw_q;
  logic [audio_serial_pkg::WW_W-1:0] ww_q;
  logic [audio_serial_pkg::SLOTS_W-1:0] slots_q;
  logic tx_err_q;
  logic rx_err_q;
  logic [31:0] rdata_q;
  logic rx_pop_ok_q;

  // fifo signals
  logic tx_push;
  logic tx_pop;
  logic tx_clr;
  logic [DW-1:0] tx_head;
  logic [LW-1:0] tx_level;
  logic tx_empty;
  logic tx_full;
  logic rx_push;
  logic rx_pop;
  logic rx_clr;
  logic [DW-1:0] rx_head;
  logic [LW-1:0] rx_level;
  logic rx_empty;
  logic rx_full;
  logic [DW-1:0] rx_word;

  // bus decode
  logic setup;
  logic wr;
  logic rd;
  logic mapped;
  logic [LW-1:0] wm_wr;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign mapped = (paddr == audio_serial_pkg::TX_CSR_OFS) || (paddr == audio_serial_pkg::TX_WM_OFS)
                  || (paddr == audio_serial_pkg::TX_MASK_OFS) || (paddr == audio_serial_pkg::TX_DATA_OFS)
                  || (paddr == audio_serial_pkg::RX_CSR_OFS) || (paddr == audio_serial_pkg::RX_WM_OFS)
                  || (paddr == audio_serial_pkg::RX_MASK_OFS) || (paddr == audio_serial_pkg::RX_DATA_OFS)
                  || (paddr == audio_serial_pkg::LINK_CFG_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rdata_q;
  // watermark above eight is held at eight
  assign wm_wr = (pwdata[LW-1:0] > audio_serial_pkg::WM_MAX) ? audio_serial_pkg::WM_MAX : pwdata[LW-1:0];

  // flags
  logic tx_req_flag;
  logic rx_req_flag;
  logic tx_warn_flag;
  logic rx_warn_flag;
  assign tx_req_flag = (tx_level <= tx_wm_q);
  assign rx_req_flag = (rx_level > rx_wm_q);
  assign tx_warn_flag = tx_empty;
  assign rx_warn_flag = rx_full;

  // separate requests per direction, gated by enables
  assign tx_dma_req = (tx_req_flag && tx_ctrl_q[audio_serial_pkg::CSR_REQ_DE_BIT])
                      || (tx_warn_flag && tx_ctrl_q[audio_serial_pkg::CSR_WARN_DE_BIT]);
  assign rx_dma_req = (rx_req_flag && rx_ctrl_q[audio_serial_pkg::CSR_REQ_DE_BIT])
                      || (rx_warn_flag && rx_ctrl_q[audio_serial_pkg::CSR_WARN_DE_BIT]);
  assign tx_irq = (tx_req_flag && tx_ctrl_q[audio_serial_pkg::CSR_REQ_IE_BIT])
                  || (tx_warn_flag && tx_ctrl_q[audio_serial_pkg::CSR_WARN_IE_BIT]);
  assign rx_irq = (rx_req_flag && rx_ctrl_q[audio_serial_pkg::CSR_REQ_IE_BIT])
                  || (rx_warn_flag && rx_ctrl_q[audio_serial_pkg::CSR_WARN_IE_BIT]);

  function automatic logic [31:0] csr_view(input logic [audio_serial_pkg::CSR_CTRL_W-1:0] ctrl,
                                           input logic req, input logic warn, input logic err);
    logic [31:0] v;
    v = '0;
    v[audio_serial_pkg::CSR_CTRL_W-1:0] = ctrl;
    v[audio_serial_pkg::CSR_REQ_FLAG_BIT] = req;
    v[audio_serial_pkg::CSR_WARN_FLAG_BIT] = warn;
    v[audio_serial_pkg::CSR_ERR_FLAG_BIT] = err;
    return v;
  endfunction

  // read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= '0;
      rx_pop_ok_q <= 1'b0;
    end else if (setup && !pwrite) begin
      rx_pop_ok_q <= (paddr == audio_serial_pkg::RX_DATA_OFS) && !rx_empty;
      unique case (paddr)
        audio_serial_pkg::TX_CSR_OFS: rdata_q <= csr_view(tx_ctrl_q, tx_req_flag, tx_warn_flag, tx_err_q);
        audio_serial_pkg::RX_CSR_OFS: rdata_q <= csr_view(rx_ctrl_q, rx_req_flag, rx_warn_flag, rx_err_q);
        audio_serial_pkg::TX_WM_OFS: rdata_q <= 32'(tx_wm_q);
        audio_serial_pkg::RX_WM_OFS: rdata_q <= 32'(rx_wm_q);
        audio_serial_pkg::TX_MASK_OFS: rdata_q <= 32'(tx_mask_q);
        audio_serial_pkg::RX_MASK_OFS: rdata_q <= 32'(rx_mask_q);
        audio_serial_pkg::RX_DATA_OFS: rdata_q <= rx_empty ? '0 : rx_head;
        audio_serial_pkg::LINK_CFG_OFS: begin
          rdata_q <= '0;
          rdata_q[audio_serial_pkg::LINE_EN_BIT] <= line_en_q;
          rdata_q[audio_serial_pkg::BCLK_DIR_BIT] <= bclk_dir_q;
          rdata_q[audio_serial_pkg::FS_DIR_BIT] <= fs_dir_q;
          rdata_q[audio_serial_pkg::FS_EARLY_BIT] <= fs_early_q;
          rdata_q[audio_serial_pkg::FSW_LSB +: audio_serial_pkg::FSW_W] <= fsw_q;
          rdata_q[audio_serial_pkg::WW_LSB +: audio_serial_pkg::WW_W] <= ww_q;
          rdata_q[audio_serial_pkg::SLOTS_LSB +: audio_serial_pkg::SLOTS_W] <= slots_q;
        end
        default: rdata_q <= '0;
      endcase
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_ctrl_q <= audio_serial_pkg::CSR_RST;
      rx_ctrl_q <= audio_serial_pkg::CSR_RST;
      tx_wm_q <= audio_serial_pkg::WM_RST;
      rx_wm_q <= audio_serial_pkg::WM_RST;
      tx_mask_q <= audio_serial_pkg::MASK_RST;
      rx_mask_q <= audio_serial_pkg::MASK_RST;
      line_en_q <= 1'b0;
      bclk_dir_q <= 1'b0;
      fs_dir_q <= 1'b0;
      fs_early_q <= 1'b0;
      fsw_q <= audio_serial_pkg::FSW_RST;
      ww_q <= audio_serial_pkg::WW_RST;
      slots_q <= audio_serial_pkg::SLOTS_RST;
    end else if (wr) begin
      unique case (paddr)
        audio_serial_pkg::TX_CSR_OFS: tx_ctrl_q <= pwdata[audio_serial_pkg::CSR_CTRL_W-1:0];
        audio_serial_pkg::RX_CSR_OFS: rx_ctrl_q <= pwdata[audio_serial_pkg::CSR_CTRL_W-1:0];
        audio_serial_pkg::TX_WM_OFS: tx_wm_q <= wm_wr;
        audio_serial_pkg::RX_WM_OFS: rx_wm_q <= wm_wr;
        audio_serial_pkg::TX_MASK_OFS: tx_mask_q <= pwdata[audio_serial_pkg::MASK_W-1:0];
        audio_serial_pkg::RX_MASK_OFS: rx_mask_q <= pwdata[audio_serial_pkg::MASK_W-1:0];
        audio_serial_pkg::LINK_CFG_OFS: begin
          line_en_q <= pwdata[audio_serial_pkg::LINE_EN_BIT];
          bclk_dir_q <= pwdata[audio_serial_pkg::BCLK_DIR_BIT];
          fs_dir_q <= pwdata[audio_serial_pkg::FS_DIR_BIT];
          fs_early_q <= pwdata[audio_serial_pkg::FS_EARLY_BIT];
          fsw_q <= pwdata[audio_serial_pkg::FSW_LSB +: audio_serial_pkg::FSW_W];
          ww_q <= pwdata[audio_serial_pkg::WW_LSB +: audio_serial_pkg::WW_W];
          slots_q <= pwdata[audio_serial_pkg::SLOTS_LSB +: audio_serial_pkg::SLOTS_W];
        end
        default: ;
      endcase
    end
  end

  logic tx_en;
  logic rx_en;
  assign tx_en = tx_ctrl_q[audio_serial_pkg::CSR_EN_BIT];
  assign rx_en = rx_ctrl_q[audio_serial_pkg::CSR_EN_BIT];
  assign tx_push = wr && (paddr == audio_serial_pkg::TX_DATA_OFS);
  assign rx_pop = rd && rx_pop_ok_q;
  assign tx_clr = wr && (paddr == audio_serial_pkg::TX_CSR_OFS) && pwdata[audio_serial_pkg::CSR_PTR_RST_BIT];
  assign rx_clr = wr && (paddr == audio_serial_pkg::RX_CSR_OFS) && pwdata[audio_serial_pkg::CSR_PTR_RST_BIT];

  word_fifo #(.WIDTH(DW), .DEPTH(audio_serial_pkg::FIFO_DEPTH), .LW(LW)) tx_fifo (
    .clk(mclk), .rst(sys_rst), .clr(tx_clr), .push(tx_push), .wdata(pwdata), .pop(tx_pop),
    .rdata(tx_head), .level(tx_level), .empty(tx_empty), .full(tx_full)
  );
  word_fifo #(.WIDTH(DW), .DEPTH(audio_serial_pkg::FIFO_DEPTH), .LW(LW)) rx_fifo (
    .clk(mclk), .rst(sys_rst), .clr(rx_clr), .push(rx_push), .wdata(rx_word), .pop(rx_pop),
    .rdata(rx_head), .level(rx_level), .empty(rx_empty), .full(rx_full)
  );

  // pin synchronisers
  logic [1:0] bclk_sync_q;
  logic [1:0] fs_sync_q;
  logic [1:0] rxd_sync_q;
  logic bclk_prev_q;
  logic fs_prev_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bclk_sync_q <= '0;
      fs_sync_q <= '0;
      rxd_sync_q <= '0;
      bclk_prev_q <= 1'b0;
    end else begin
      bclk_sync_q <= {bclk_sync_q[0], bclk_in};
      fs_sync_q <= {fs_sync_q[0], fs_in};
      rxd_sync_q <= {rxd_sync_q[0], rxd_in};
      bclk_prev_q <= bclk_sync_q[1];
    end
  end

  // bit clock: divided here in master mode, edges of the pin otherwise
  logic link_on;
  logic [DIV_W-1:0] div_q;
  logic bclk_q;
  logic rise_en;
  logic fall_en;
  logic div_tick;
  assign link_on = tx_en || rx_en;
  assign div_tick = (div_q == DIV_LAST);
  assign rise_en = link_on && (bclk_dir_q ? (div_tick && !bclk_q) : (bclk_sync_q[1] && !bclk_prev_q));
  assign fall_en = link_on && (bclk_dir_q ? (div_tick && bclk_q) : (!bclk_sync_q[1] && bclk_prev_q));
  assign bclk_out = bclk_q;
  assign bclk_oe = bclk_dir_q;
  assign fs_oe = fs_dir_q;

  always_ff @(posedge mclk) begin
    if (sys_rst || !link_on || !bclk_dir_q) begin
      div_q <= '0;
      bclk_q <= 1'b0;
    end else begin
      div_q <= div_tick ? '0 : div_q + 1'b1;
      if (div_tick) begin
        bclk_q <= !bclk_q;
      end
    end
  end

  // frame position; slave frame sync realigns it
  logic [audio_serial_pkg::WW_W-1:0] bit_q;
  logic [audio_serial_pkg::SLOTS_W-1:0] slot_q;
  logic framed_q;
  logic fs_rise;
  logic [audio_serial_pkg::WW_W-1:0] nbit;
  logic [audio_serial_pkg::SLOTS_W-1:0] nslot;
  logic [audio_serial_pkg::WW_W-1:0] cbit;
  logic [audio_serial_pkg::SLOTS_W-1:0] cslot;
  logic fs_next;
  logic framed;

  assign fs_rise = rise_en && !fs_dir_q && fs_sync_q[1] && !fs_prev_q;
  assign framed = fs_dir_q || framed_q;
  assign nbit = (bit_q == ww_q) ? '0 : bit_q + 1'b1;
  assign nslot = (bit_q != ww_q) ? slot_q : ((slot_q == slots_q) ? '0 : slot_q + 1'b1);
  // late sync marks the bit being sampled now as bit zero
  assign cbit = (fs_rise && !fs_early_q) ? '0 : bit_q;
  assign cslot = (fs_rise && !fs_early_q) ? '0 : slot_q;
  assign fs_next = fs_early_q ? (((nslot == '0) && (5'(nbit) < fsw_q))
                                 || ((nslot == slots_q) && (nbit == ww_q)))
                              : ((nslot == '0) && (5'(nbit) <= fsw_q));

  always_ff @(posedge mclk) begin
    if (sys_rst || !link_on) begin
      bit_q <= ww_q;
      slot_q <= slots_q;
      framed_q <= 1'b0;
      fs_prev_q <= 1'b0;
      fs_out <= 1'b0;
    end else begin
      if (rise_en) begin
        fs_prev_q <= fs_sync_q[1];
      end
      if (fs_rise) begin
        framed_q <= 1'b1;
        bit_q <= fs_early_q ? ww_q : '0;
        slot_q <= fs_early_q ? slots_q : '0;
      end else if (fall_en) begin
        bit_q <= nbit;
        slot_q <= nslot;
        fs_out <= fs_dir_q && fs_next;
      end
    end
  end

  // transmit path: a word per unmasked slot, shifted out msb first on falling edges
  logic tx_run;
  logic [DW-1:0] tx_sh_q;
  logic tx_take;
  logic tx_underrun;
  assign tx_run = tx_en && line_en_q && framed && !(tx_err_q && !tx_ctrl_q[audio_serial_pkg::CSR_CONT_BIT]);
  assign tx_take = fall_en && tx_run && (nbit == '0) && !tx_mask_q[nslot];
  assign tx_pop = tx_take && !tx_empty;
  assign tx_underrun = tx_take && tx_empty;
  assign txd_out = tx_sh_q[DW-1];

  always_ff @(posedge mclk) begin
    if (sys_rst || !link_on) begin
      tx_sh_q <= '0;
    end else if (fall_en) begin
      if (nbit == '0) begin
        tx_sh_q <= tx_pop ? tx_head : '0;
      end else begin
        tx_sh_q <= {tx_sh_q[DW-2:0], 1'b0};
      end
    end
  end

  // receive path: sampled on rising edges, pushed at the last bit of an unmasked slot
  logic rx_run;
  logic [DW-1:0] rx_sh_q;
  logic rx_store;
  logic rx_overrun;
  assign rx_run = rx_en && line_en_q && (framed || fs_rise) && !(rx_err_q && !rx_ctrl_q[audio_serial_pkg::CSR_CONT_BIT]);
  assign rx_word = (cbit == '0) ? DW'(rxd_sync_q[1]) : {rx_sh_q[DW-2:0], rxd_sync_q[1]};
  assign rx_store = rise_en && rx_run && (cbit == ww_q) && !rx_mask_q[cslot];
  assign rx_push = rx_store && !rx_full;
  assign rx_overrun = rx_store && rx_full;

  always_ff @(posedge mclk) begin
    if (sys_rst || !link_on) begin
      rx_sh_q <= '0;
    end else if (rise_en) begin
      rx_sh_q <= rx_word;
    end
  end

  // error flags: sticky, write one to clear, a new error in the same cycle wins
  logic tx_err_clr;
  logic rx_err_clr;
  assign tx_err_clr = wr && (paddr == audio_serial_pkg::TX_CSR_OFS) && pwdata[audio_serial_pkg::CSR_ERR_FLAG_BIT];
  assign rx_err_clr = wr && (paddr == audio_serial_pkg::RX_CSR_OFS) && pwdata[audio_serial_pkg::CSR_ERR_FLAG_BIT];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_err_q <= 1'b0;
      rx_err_q <= 1'b0;
    end else begin
      if (tx_underrun) begin
        tx_err_q <= 1'b1;
      end else if (tx_err_clr) begin
        tx_err_q <= 1'b0;
      end
      if (rx_overrun) begin
        rx_err_q <= 1'b1;
      end else if (rx_err_clr) begin
        rx_err_q <= 1'b0;
      end
    end
  end
endmodule

/* hdl/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int LW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic pop,
  output logic [WIDTH-1:0] rdata,
  output logic [LW-1:0] level,
  output logic empty,
  output logic full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic push_ok;
  logic pop_ok;

  assign empty = (level == '0);
  assign full = (level == FULL_LVL);
  assign push_ok = push && !full;
  assign pop_ok = pop && !empty;
  assign rdata = mem_q[rptr_q];

  always_ff @(posedge clk) begin
    if (push_ok) begin
      mem_q[wptr_q] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      wptr_q <= '0;
      rptr_q <= '0;
      level <= '0;
    end else begin
      if (push_ok) begin
        wptr_q <= (wptr_q == LAST) ? '0 : wptr_q + 1'b1;
      end
      if (pop_ok) begin
        rptr_q <= (rptr_q == LAST) ? '0 : rptr_q + 1'b1;
      end
      if (push_ok && !pop_ok) begin
        level <= level + 1'b1;
      end else if (pop_ok && !push_ok) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule

/* verif/audio_serial_fifo_ctrl_asserts.sv */
`timescale 1ns/1ps
module audio_serial_asserts #(
  parameter int BCLK_HALF = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bclk_out,
  input wire logic bclk_oe,
  input wire logic fs_out,
  input wire logic fs_oe,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic tx_dma_req,
  input wire logic rx_dma_req
);
  logic [5:0] txc_q;
  logic [5:0] rxc_q;
  logic [2:0] cfg_q;
  wire wr = psel && penable && pwrite;
  // shadow of the enable bits as software wrote them
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txc_q <= '0;
      rxc_q <= '0;
      cfg_q <= '0;
    end else if (wr) begin
      if (paddr == audio_serial_pkg::TX_CSR_OFS) txc_q <= pwdata[5:0];
      if (paddr == audio_serial_pkg::RX_CSR_OFS) rxc_q <= pwdata[5:0];
      if (paddr == audio_serial_pkg::LINK_CFG_OFS) cfg_q <= pwdata[2:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_unmapped;
    s_access ##0 (paddr > 8'h20 || paddr[1:0] != 2'b00);
  endsequence
  a_pready_high: assert property (pready) else $error("pready low");
  a_slverr_unmapped: assert property (s_unmapped |-> pslverr) else $error("no slave error");
  a_slverr_mapped: assert property (s_access ##0 paddr <= 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("slave error on mapped address");
  a_tx_dma_gate: assert property (tx_dma_req |-> txc_q[1] || txc_q[2]) else $error("tx dma ungated");
  a_rx_dma_gate: assert property (rx_dma_req |-> rxc_q[1] || rxc_q[2]) else $error("rx dma ungated");
  a_tx_irq_gate: assert property (tx_irq |-> txc_q[3] || txc_q[4]) else $error("tx irq ungated");
  a_rx_irq_gate: assert property (rx_irq |-> rxc_q[3] || rxc_q[4]) else $error("rx irq ungated");
  a_oe_follow: assert property (bclk_oe == cfg_q[1] && fs_oe == cfg_q[2]) else $error("oe mismatch");
  a_fs_frame_edge: assert property ($rose(fs_out) |-> $fell(bclk_out)) else $error("fs off edge");
endmodule
bind audio_serial_fifo_ctrl audio_serial_asserts #(.BCLK_HALF(BCLK_HALF)) asserts_i (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
  .fs_out(fs_out), .fs_oe(fs_oe), .tx_irq(tx_irq), .rx_irq(rx_irq), .tx_dma_req(tx_dma_req),
  .rx_dma_req(rx_dma_req));

/* verif/codec_model.sv */
`timescale 1ns/1ps
module codec_model (
  input wire logic bclk_out,
  input wire logic fs_out,
  input wire logic txd_out,
  input wire logic bclk_oe,
  input wire logic fs_oe,
  input wire logic slave_run,
  output logic bclk_in,
  output logic fs_in,
  output logic rxd_in,
  output logic [31:0] tx_word
);
  localparam logic [31:0] RX_WORD = 32'hC3A5_0F69;
  logic [31:0] sh = '0;
  logic fs_d = 1'b0;
  int bit_n = 63;
  int sbit = 63;
  wire bc = bclk_oe ? bclk_out : bclk_in;
  wire fs = fs_oe ? fs_out : fs_in;
  initial begin
    bclk_in = 1'b0;
    fs_in = 1'b0;
    rxd_in = 1'b0;
    tx_word = '0;
  end
  // link clock stands still outside slave runs; each run starts a fresh frame
  always #160 begin
    if (slave_run === 1'b1) begin
      bclk_in = ~bclk_in;
    end else begin
      bclk_in = 1'b0;
      sbit = 63;
    end
  end
  // two 32-bit slots per frame, sync high for the first slot; data msb first, unused bits keep toggling
  always @(negedge bclk_in) begin
    if (slave_run === 1'b1) begin
      sbit = (sbit + 1) % 64;
      fs_in = sbit < 32;
      rxd_in = (sbit < 32) ? RX_WORD[31 - sbit] : ~rxd_in;
    end
  end
  always @(posedge bc) begin
    bit_n = (fs && !fs_d) ? 0 : bit_n + 1;
    fs_d = fs;
    sh = {sh[30:0], txd_out};
    if (bit_n == 31) tx_word = sh;
  end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] TXC = audio_serial_pkg::TX_CSR_OFS;
  localparam logic [7:0] TXW = audio_serial_pkg::TX_WM_OFS;
  localparam logic [7:0] LNK = audio_serial_pkg::LINK_CFG_OFS;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, sl, slave_run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, tx_word;
  logic bclk_in, fs_in, rxd_in, bclk_out, bclk_oe, fs_out, fs_oe, txd_out;
  logic tx_irq, rx_irq, tx_dma_req, rx_dma_req;
  int miscompares = 0;
  int cmp_count = 0;
  audio_serial_fifo_ctrl audio_serial_fifo_ctrl_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bclk_in(bclk_in), .fs_in(fs_in), .rxd_in(rxd_in), .bclk_out(bclk_out),
    .bclk_oe(bclk_oe), .fs_out(fs_out), .fs_oe(fs_oe), .txd_out(txd_out), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
  codec_model codec_model_i (.bclk_out(bclk_out), .fs_out(fs_out), .txd_out(txd_out), .bclk_oe(bclk_oe),
    .fs_oe(fs_oe), .slave_run(slave_run), .bclk_in(bclk_in), .fs_in(fs_in), .rxd_in(rxd_in), .tx_word(tx_word));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task end_of_test;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    give_up(n, 20);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    check(rdat, e);
  endtask
  // waits for the codec to capture the next word
  task automatic wait_word();
    int n;
    logic [31:0] last;
    n = 0;
    last = tx_word;
    while (tx_word === last && n < 1500) begin
      @(posedge mclk);
      n++;
    end
    give_up(n, 1500);
  endtask
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, slave_run} = '0;
    sys_rst = 1'b1;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(TXC, 32'h0003_0000);
    rd(audio_serial_pkg::RX_CSR_OFS, 32'h0000_0000);
    rd(audio_serial_pkg::TX_MASK_OFS, 32'h0000_0000);
    rd(LNK, 32'h011F_1F00);
    rd(8'h24, 32'h0000_0000);
    check({31'd0, sl}, 32'h0000_0001);
    wr(TXW, 32'h0000_0009);
    rd(TXW, 32'h0000_0008);
    wr(TXW, 32'h0000_0003);
    wr(TXC, 32'h0000_0016);
    check({31'd0, tx_irq}, 32'h0000_0001);
    check({31'd0, rx_irq}, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      wr(audio_serial_pkg::TX_DATA_OFS, 32'h5A00_0000 | i);
      rd(TXC, 32'h0000_0016 | ((i < 3) ? 32'h0001_0000 : 32'h0000_0000));
      check({31'd0, tx_dma_req}, (i < 3) ? 32'h0000_0001 : 32'h0000_0000);
    end
    wr(audio_serial_pkg::TX_DATA_OFS, 32'hDEAD_0009);
    wr(audio_serial_pkg::TX_MASK_OFS, 32'h0000_FFFE);
    wr(LNK, 32'h011F_1F06);
    wr(TXC, 32'h0000_0001);
    wr(LNK, 32'h011F_1F07);
    for (int i = 0; i < 8; i++) begin
      wait_word();
      check(tx_word, 32'h5A00_0000 | i);
    end
    for (int n = 0; n < 400 && !rdat[18]; n++) apb(TXC, 1'b0, 32'h0000_0000);
    check(rdat, 32'h0007_0001);
    wr(audio_serial_pkg::TX_DATA_OFS, 32'h5A00_0008);
    repeat (1100) @(posedge mclk);
    rd(TXC, 32'h0005_0001);
    wr(TXC, 32'h0004_0001);
    wait_word();
    check(tx_word, 32'h5A00_0008);
    wr(TXC, 32'h0000_0000);
    wr(TXC, 32'h0004_0000);
    wr(audio_serial_pkg::TX_DATA_OFS, 32'h0000_0000);
    wr(TXC, 32'h0000_0100);
    rd(TXC, 32'h0003_0000);
    wr(LNK, 32'h011F_1F01);
    wr(audio_serial_pkg::RX_MASK_OFS, 32'h0000_FFFE);
    wr(audio_serial_pkg::RX_CSR_OFS, 32'h0000_0003);
    slave_run <= 1'b1;
    for (int n = 0; n < 3000 && rx_dma_req !== 1'b1; n++) @(posedge mclk);
    check({31'd0, rx_dma_req}, 32'h0000_0001);
    check({31'd0, rx_irq}, 32'h0000_0000);
    wr(audio_serial_pkg::RX_CSR_OFS, 32'h0000_000B);
    check({31'd0, rx_irq}, 32'h0000_0001);
    rd(audio_serial_pkg::RX_DATA_OFS, codec_model_i.RX_WORD);
    slave_run <= 1'b0;
    end_of_test();
  end
endmodule
